/* File: logic/afi_top.v */
// Sample buffer, event latching and interrupt pin logic of the three-axis sensor
`timescale 1ns/1ps
`include "afi_regs.vh"
module afi_top #(
  parameter TICKS_PER_SEC = `AFI_TICKS_PER_SEC
) (
  input  wire                   sys_clk_i,
  input  wire                   reset_i,
  input  wire [`AFI_ADDR_W-1:0] reg_addr_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  input  wire [7:0]             reg_wdata_i,
  input  wire                   chip_select_n_i,
  output reg  [7:0]             reg_rdata_o,
  input  wire                   sample_valid_i,
  input  wire [15:0]            sample_x_i,
  input  wire [15:0]            sample_y_i,
  input  wire [15:0]            sample_z_i,
  input  wire [7:0]             accel_mag_i,
  output reg                    irq_pin_one_o,
  output reg                    irq_pin_two_o
);
  function is_readout;
    input [`AFI_ADDR_W-1:0] a;
    begin
      is_readout = (a >= `AFI_OFS_READOUT_FIRST) && (a <= `AFI_OFS_READOUT_LAST);
    end
  endfunction

  reg  [7:0]  motion_threshold;
  reg  [7:0]  stillness_threshold;
  reg  [7:0]  stillness_time;
  reg  [7:0]  irq_enables;
  reg  [7:0]  irq_pin_select;
  reg  [7:0]  output_format;
  reg  [7:0]  buffer_control;
  reg  [47:0] sample_readout;
  reg         readout_fresh;
  reg         in_data_read;
  reg  [`AFI_ADDR_W-1:0] last_rd_addr;
  reg         motion_flag;
  reg         stillness_flag;
  reg         watermark_flag;
  reg         overrun_flag;
  reg         triggered;
  reg         trig_level_q;
  reg  [31:0] tick_cnt;
  reg  [8:0]  still_secs;
  reg  [7:0]  next_rdata;

  wire [1:0]  mode = buffer_control[7:6];
  wire [4:0]  samples_n = buffer_control[4:0];
  wire        bypass = (mode == `AFI_MODE_BYPASS);
  wire [47:0] incoming = {sample_z_i, sample_y_i, sample_x_i};
  wire [47:0] buf_head;
  wire [5:0]  buf_count;
  wire        buf_full = (buf_count == `AFI_DEPTH);
  wire        buf_empty = (buf_count == 6'h00);

  wire        cause_read = reg_rd_i && reg_addr_i == `AFI_OFS_IRQ_CAUSE;
  wire        ctl_write = reg_wr_i && reg_addr_i == `AFI_OFS_BUF_CONTROL;
  wire        to_bypass = ctl_write && reg_wdata_i[7:6] == `AFI_MODE_BYPASS;
  // Leaving a burst through the control register or dropping select closes the read
  wire        read_end = in_data_read && (chip_select_n_i || (reg_rd_i
                && reg_addr_i == `AFI_OFS_BUF_CONTROL
                && last_rd_addr == `AFI_OFS_READOUT_LAST));
  // Refill only while no burst is in flight so the bytes of one sample stay together
  wire        pop_now = !bypass && !readout_fresh && !in_data_read && !buf_empty;

  wire        capture_stop = (mode == `AFI_MODE_FIFO) || (mode == `AFI_MODE_TRIGGER && triggered);
  wire        push_now = sample_valid_i && !bypass && !(capture_stop && buf_full);
  wire        drop_oldest = push_now && buf_full;

  wire [7:0]  cause = {readout_fresh, 2'b00, motion_flag, stillness_flag, 1'b0,
                       watermark_flag, overrun_flag};
  wire [7:0]  active = cause & irq_enables & `AFI_IRQ_MASK;
  wire        lvl_one = |(active & ~irq_pin_select);
  wire        lvl_two = |(active & irq_pin_select);
  wire        trig_level = buffer_control[`AFI_BIT_TRIG_PIN] ? lvl_two : lvl_one;
  wire        trig_event = mode == `AFI_MODE_TRIGGER && !triggered && trig_level
                           && !trig_level_q;

  afi_buffer u_buffer (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clear_i   (bypass || to_bypass),
    .push_i    (push_now),
    .pop_i     (pop_now || drop_oldest),
    .trim_i    (trig_event),
    .keep_i    (samples_n),
    .wdata_i   (incoming),
    .rdata_o   (buf_head),
    .count_o   (buf_count)
  );

  // Configuration registers
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      motion_threshold    <= `AFI_RST_BYTE;
      stillness_threshold <= `AFI_RST_BYTE;
      stillness_time      <= `AFI_RST_BYTE;
      irq_enables         <= `AFI_RST_BYTE;
      irq_pin_select      <= `AFI_RST_BYTE;
      output_format       <= `AFI_RST_BYTE;
      buffer_control      <= `AFI_RST_BYTE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `AFI_OFS_MOTION_THRESH: motion_threshold <= reg_wdata_i;
        `AFI_OFS_STILL_THRESH:  stillness_threshold <= reg_wdata_i;
        `AFI_OFS_STILL_TIME:    stillness_time <= reg_wdata_i;
        `AFI_OFS_IRQ_ENABLES:   irq_enables <= reg_wdata_i & `AFI_IRQ_MASK;
        `AFI_OFS_IRQ_PIN_SEL:   irq_pin_select <= reg_wdata_i & `AFI_IRQ_MASK;
        `AFI_OFS_OUT_FORMAT:    output_format <= reg_wdata_i & 8'hef;
        `AFI_OFS_BUF_CONTROL:   buffer_control <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Data registers and the unread marker behind the new-sample flag
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      sample_readout <= 48'h000000000000;
      readout_fresh  <= 1'b0;
    end else if (bypass) begin
      if (sample_valid_i) begin
        sample_readout <= incoming;
        readout_fresh  <= 1'b1;
      end else if (read_end) begin
        readout_fresh  <= 1'b0;
      end
    end else if (pop_now) begin
      sample_readout <= buf_head;
      readout_fresh  <= 1'b1;
    end else if (read_end) begin
      readout_fresh  <= 1'b0;
    end
  end

  // Burst tracking across the data registers
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      in_data_read <= 1'b0;
      last_rd_addr <= 6'h00;
    end else begin
      if (reg_rd_i) begin
        last_rd_addr <= reg_addr_i;
      end
      if (read_end) begin
        in_data_read <= 1'b0;
      end else if (reg_rd_i && is_readout(reg_addr_i) && !chip_select_n_i) begin
        in_data_read <= 1'b1;
      end
    end
  end

  // Event flags; a fresh event in the clearing cycle wins
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      motion_flag    <= 1'b0;
      stillness_flag <= 1'b0;
      watermark_flag <= 1'b0;
      overrun_flag   <= 1'b0;
    end else begin
      if (sample_valid_i && accel_mag_i > motion_threshold) begin
        motion_flag <= 1'b1;
      end else if (cause_read) begin
        motion_flag <= 1'b0;
      end
      if (still_secs > {1'b0, stillness_time}) begin
        stillness_flag <= 1'b1;
      end else if (cause_read) begin
        stillness_flag <= 1'b0;
      end
      if (buf_count == {1'b0, samples_n}) begin
        watermark_flag <= 1'b1;
      end else if (buf_count < {1'b0, samples_n}) begin
        watermark_flag <= 1'b0;
      end
      if (bypass) begin
        if (sample_valid_i && readout_fresh) begin
          overrun_flag <= 1'b1;
        end else if (read_end) begin
          overrun_flag <= 1'b0;
        end
      end else if (buf_full) begin
        overrun_flag <= 1'b1;
      end else if (pop_now) begin
        overrun_flag <= 1'b0;
      end
    end
  end

  // Stillness timing in whole seconds; one tick count shared by all settings
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      tick_cnt   <= 32'h00000000;
      still_secs <= 9'h000;
    end else if (accel_mag_i >= stillness_threshold) begin
      tick_cnt   <= 32'h00000000;
      still_secs <= 9'h000;
    end else if (tick_cnt == TICKS_PER_SEC - 1) begin
      tick_cnt   <= 32'h00000000;
      if (still_secs != 9'h1ff) begin
        still_secs <= still_secs + 9'h001;
      end
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // Trigger capture state; only bypass rearms it
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      triggered    <= 1'b0;
      trig_level_q <= 1'b0;
    end else begin
      trig_level_q <= trig_level;
      if (bypass || to_bypass) begin
        triggered <= 1'b0;
      end else if (trig_event) begin
        triggered <= 1'b1;
      end
    end
  end

  // Interrupt pins; both idle low after reset with the invert bit clear
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_pin_one_o <= 1'b0;
      irq_pin_two_o <= 1'b0;
    end else begin
      irq_pin_one_o <= lvl_one ^ output_format[`AFI_BIT_INVERT];
      irq_pin_two_o <= lvl_two ^ output_format[`AFI_BIT_INVERT];
    end
  end

  // Read data mux
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `AFI_OFS_MOTION_THRESH: next_rdata = motion_threshold;
      `AFI_OFS_STILL_THRESH:  next_rdata = stillness_threshold;
      `AFI_OFS_STILL_TIME:    next_rdata = stillness_time;
      `AFI_OFS_IRQ_ENABLES:   next_rdata = irq_enables;
      `AFI_OFS_IRQ_PIN_SEL:   next_rdata = irq_pin_select;
      `AFI_OFS_IRQ_CAUSE:     next_rdata = cause;
      `AFI_OFS_OUT_FORMAT:    next_rdata = output_format;
      6'h32:                  next_rdata = sample_readout[7:0];
      6'h33:                  next_rdata = sample_readout[15:8];
      6'h34:                  next_rdata = sample_readout[23:16];
      6'h35:                  next_rdata = sample_readout[31:24];
      6'h36:                  next_rdata = sample_readout[39:32];
      6'h37:                  next_rdata = sample_readout[47:40];
      `AFI_OFS_BUF_CONTROL:   next_rdata = buffer_control;
      `AFI_OFS_BUF_FILL:      next_rdata = {triggered, 1'b0, buf_count};
      default:                next_rdata = 8'h00;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule // afi_top

/* File: logic/afi_regs.vh */
// Register map, field positions, reset values and timing counts of the sample buffer block
// Functional notes
// - Pins active high; low when invert bit set
// - Enabled interrupts only, routed by pin-select bits
// - Latched events; data or cause read clears
// - New-sample flag follows unread fresh data
// - Motion flag when magnitude exceeds threshold
// - Stillness flag after below-threshold time expires
// - Watermark when count equals samples field
// - Overrun: overwrite in bypass, full otherwise
// - 32-level buffer, four modes by field
// - Bypass keeps buffer empty and idle
// - First-in first-out mode stops when full
// - Stream mode keeps newest 32 samples
// - Trigger keeps last n, then first-in first-out
// - One trigger only until bypass rearms
// - Data reads return oldest buffered sample
// - Single-byte read drops rest of sample
// - Read ends at 0x37 to 0x38 or deselect
`ifndef AFI_REGS_VH
`define AFI_REGS_VH

`define AFI_ADDR_W            6
`define AFI_OFS_MOTION_THRESH 6'h24
`define AFI_OFS_STILL_THRESH  6'h25
`define AFI_OFS_STILL_TIME    6'h26
`define AFI_OFS_IRQ_ENABLES   6'h2e
`define AFI_OFS_IRQ_PIN_SEL   6'h2f
`define AFI_OFS_IRQ_CAUSE     6'h30
`define AFI_OFS_OUT_FORMAT    6'h31
`define AFI_OFS_READOUT_FIRST 6'h32
`define AFI_OFS_READOUT_LAST  6'h37
`define AFI_OFS_BUF_CONTROL   6'h38
`define AFI_OFS_BUF_FILL      6'h39

`define AFI_BIT_DATA_READY    7
`define AFI_BIT_MOTION        4
`define AFI_BIT_STILLNESS     3
`define AFI_BIT_WATERMARK     1
`define AFI_BIT_OVERRUN       0
`define AFI_IRQ_MASK          8'h9b
`define AFI_BIT_INVERT        5
`define AFI_BIT_TRIG_PIN      5
`define AFI_BIT_FILL_TRIG     7

`define AFI_RST_BYTE          8'h00

`define AFI_MODE_BYPASS       2'h0
`define AFI_MODE_FIFO         2'h1
`define AFI_MODE_STREAM       2'h2
`define AFI_MODE_TRIGGER      2'h3

`define AFI_DEPTH             6'h20
`define AFI_SAMPLE_W          48

`define AFI_CLK_PERIOD_NS     100
`define AFI_SECOND_NS         1000000000
`define AFI_TICKS_PER_SEC     (`AFI_SECOND_NS / `AFI_CLK_PERIOD_NS)
`define AFI_POP_DELAY_NS      5000
`define AFI_POP_DELAY_CYC     (`AFI_POP_DELAY_NS / `AFI_CLK_PERIOD_NS)

`endif

/* File: logic/afi_buffer.v */
// Flip-flop sample store of 32 three-axis entries with trim for trigger capture
`timescale 1ns/1ps
`include "afi_regs.vh"
module afi_buffer (
  input  wire                     sys_clk_i,
  input  wire                     reset_i,
  input  wire                     clear_i,
  input  wire                     push_i,
  input  wire                     pop_i,
  input  wire                     trim_i,
  input  wire [4:0]               keep_i,
  input  wire [`AFI_SAMPLE_W-1:0] wdata_i,
  output wire [`AFI_SAMPLE_W-1:0] rdata_o,
  output wire [5:0]               count_o
);
  reg [`AFI_SAMPLE_W-1:0] mem [0:31];
  reg [4:0]               wr_ptr;
  reg [4:0]               rd_ptr;
  reg [5:0]               count;
  wire                    do_push;
  wire                    do_pop;

  // A push into a full store only lands when the oldest entry leaves at once
  assign do_push = push_i && (count != `AFI_DEPTH || pop_i);
  assign do_pop  = pop_i && count != 6'h00;
  assign rdata_o = mem[rd_ptr];
  assign count_o = count;

  always @(posedge sys_clk_i) begin
    if (do_push && !clear_i && !trim_i) begin
      mem[wr_ptr] <= wdata_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i || clear_i) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      count  <= 6'h00;
    end else if (trim_i) begin
      if (count > {1'b0, keep_i}) begin
        rd_ptr <= wr_ptr - keep_i;
        count  <= {1'b0, keep_i};
      end
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
      if (do_push && !do_pop) begin
        count <= count + 6'h01;
      end else if (do_pop && !do_push) begin
        count <= count - 6'h01;
      end
    end
  end
endmodule // afi_buffer

/* File: verif/afi_top_props.sv */
// Port checker of the sample buffer and interrupt pin block
`timescale 1ns/1ps
`include "afi_regs.vh"
module afi_top_props (
  input wire       sys_clk_i,
  input wire       reset_i,
  input wire [5:0] reg_addr_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       irq_pin_one_o,
  input wire       irq_pin_two_o
);
  // Shadow of written config; age lets the pin pipeline settle after any write
  reg  [7:0] sh [0:63];
  reg  [1:0] age;
  integer    i;
  wire [7:0] en   = sh[`AFI_OFS_IRQ_ENABLES] & `AFI_IRQ_MASK;
  wire [7:0] map  = sh[`AFI_OFS_IRQ_PIN_SEL];
  wire       inv  = sh[`AFI_OFS_OUT_FORMAT][`AFI_BIT_INVERT];
  wire       byp  = sh[`AFI_OFS_BUF_CONTROL][7:6] == `AFI_MODE_BYPASS;
  wire       fill = reg_rd_i && reg_addr_i == `AFI_OFS_BUF_FILL;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (i = 0; i < 64; i = i + 1)
        sh[i] <= 8'h00;
      age <= 2'h3;
    end else begin
      if (reg_wr_i)
        sh[reg_addr_i] <= reg_wdata_i;
      age <= reg_wr_i ? 2'h0 : age + {1'b0, age != 2'h3};
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  property p_rst; $fell(reset_i) |-> !irq_pin_one_o && !irq_pin_two_o && reg_rdata_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins or read data not idle after reset");
  property p_unmap; reg_rd_i && (reg_addr_i < 6'h24 || reg_addr_i > 6'h39) |=> reg_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_cause; reg_rd_i && reg_addr_i == `AFI_OFS_IRQ_CAUSE |=> (reg_rdata_o & ~`AFI_IRQ_MASK) == 8'h00; endproperty
  a_cause: assert property (p_cause) else $error("cause reserved bits set");
  property p_fill; fill |=> !reg_rdata_o[6] && reg_rdata_o[5:0] <= `AFI_DEPTH; endproperty
  a_fill: assert property (p_fill) else $error("fill state out of range");
  property p_empty; fill && byp && age == 2'h3 |=> reg_rdata_o[5:0] == 6'h00; endproperty
  a_empty: assert property (p_empty) else $error("buffer not empty in bypass");
  property p_one; age == 2'h3 && (en & ~map) == 8'h00 |-> irq_pin_one_o == inv; endproperty
  a_one: assert property (p_one) else $error("pin one active with nothing routed");
  property p_two; age == 2'h3 && (en & map) == 8'h00 |-> irq_pin_two_o == inv; endproperty
  a_two: assert property (p_two) else $error("pin two active with nothing routed");
  c_data: cover property (reg_rd_i && reg_addr_i == `AFI_OFS_READOUT_LAST);
  c_one: cover property (irq_pin_one_o != inv);
  c_two: cover property (irq_pin_two_o != inv);
endmodule // afi_top_props
bind afi_top afi_top_props u_props (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .irq_pin_one_o(irq_pin_one_o), .irq_pin_two_o(irq_pin_two_o)
);

/* File: verif/afi_host_model.sv */
// Host model: register accesses, sample bursts and the pop delays a host owes
`timescale 1ns/1ps
`include "afi_regs.vh"
module afi_host_model (
  input  wire       sys_clk_i,
  input  wire [7:0] rdata_i,
  output reg  [5:0] addr_o,
  output reg        wr_o,
  output reg        rd_o,
  output reg  [7:0] wdata_o,
  output reg        cs_n_o
);
  initial begin
    addr_o = 6'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
    cs_n_o = 1'b1;
  end
  task gap;
    repeat (`AFI_POP_DELAY_CYC) @(posedge sys_clk_i);
  endtask
  task wr(input [5:0] a, input [7:0] d);
    begin
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge sys_clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      @(posedge sys_clk_i);
    end
  endtask
  task rd(input [5:0] a, output [7:0] d);
    begin
      cs_n_o <= 1'b0;
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge sys_clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      @(posedge sys_clk_i);
      d = rdata_i;
      cs_n_o <= 1'b1;
      @(posedge sys_clk_i);
    end
  endtask
  // All six bytes in one burst; the step on to the control byte closes the read
  task burst(output [47:0] s);
    integer k;
    begin
      cs_n_o <= 1'b0;
      for (k = 0; k < 7; k = k + 1) begin
        addr_o <= `AFI_OFS_READOUT_FIRST + k[5:0];
        rd_o <= 1'b1;
        @(posedge sys_clk_i);
        if (k > 0)
          s[8*k-8 +: 8] = rdata_i;
      end
      rd_o <= 1'b0;
      cs_n_o <= 1'b1;
      addr_o <= 6'h00;
      gap;
    end
  endtask
endmodule // afi_host_model

/* File: verif/tb_top.sv */
// Self-checking bench of the sample buffer and interrupt pin block
`timescale 1ns/1ps
`include "afi_regs.vh"
module tb_top;
  reg         sys_clk_i = 1'b0;
  reg         reset_i   = 1'b1;
  reg         valid     = 1'b0;
  reg  [47:0] smp_in    = 48'h0;
  reg  [7:0]  mag       = 8'h00;
  wire [5:0]  addr;
  wire        wr;
  wire        rd;
  wire [7:0]  wdata;
  wire        cs_n;
  wire [7:0]  rdata;
  wire        pin1;
  wire        pin2;
  integer     fails     = 0;
  integer     cmp_count = 0;
  integer     i;
  reg  [47:0] s;
  always #50 sys_clk_i = ~sys_clk_i;
  afi_top #(.TICKS_PER_SEC(10)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .chip_select_n_i(cs_n), .reg_rdata_o(rdata),
    .sample_valid_i(valid), .sample_x_i(smp_in[15:0]), .sample_y_i(smp_in[31:16]),
    .sample_z_i(smp_in[47:32]), .accel_mag_i(mag), .irq_pin_one_o(pin1), .irq_pin_two_o(pin2)
  );
  afi_host_model host (
    .sys_clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .cs_n_o(cs_n)
  );
  function [47:0] smp(input [7:0] n);
    smp = {8'h30, n, 8'h20, n, 8'h10, n};
  endfunction
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [47:0] got, input [47:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [5:0] a, input [7:0] e);
    reg [7:0] d;
    begin
      host.rd(a, d);
      chk({40'h0, d}, {40'h0, e});
    end
  endtask
  task bc(input [7:0] n);
    begin
      host.burst(s);
      chk(s, smp(n));
    end
  endtask
  task push(input [7:0] n, input [7:0] m);
    begin
      smp_in <= smp(n);
      mag <= m;
      valid <= 1'b1;
      @(posedge sys_clk_i);
      valid <= 1'b0;
      smp_in <= ~smp(n);
      @(posedge sys_clk_i);
    end
  endtask
  // Bounded wait; running out of time ends the run
  task wpin(input e1, input e2);
    integer n;
    begin
      n = 0;
      while ((pin1 !== e1 || pin2 !== e2) && n < 20) begin
        @(posedge sys_clk_i);
        n = n + 1;
      end
      chk({46'h0, pin1, pin2}, {46'h0, e1, e2});
      if (n == 20)
        close_out;
    end
  endtask
  task s_fifo;
    begin
      host.wr(`AFI_OFS_BUF_CONTROL, 8'h44);
      for (i = 0; i < 34; i = i + 1)
        push(i[7:0], 8'h00);
      rc(`AFI_OFS_BUF_FILL, 8'h20);
      rc(`AFI_OFS_IRQ_CAUSE, 8'h83);
      for (i = 0; i < 28; i = i + 1)
        bc(i[7:0]);
      rc(`AFI_OFS_BUF_FILL, 8'h04);
      rc(`AFI_OFS_IRQ_CAUSE, 8'h82);
      bc(8'd28);
      rc(`AFI_OFS_IRQ_CAUSE, 8'h80);
    end
  endtask
  task s_bypass_irq;
    begin
      host.wr(`AFI_OFS_BUF_CONTROL, 8'h00);
      push(8'd200, 8'h00);
      push(8'd201, 8'h00);
      rc(`AFI_OFS_IRQ_CAUSE, 8'h83);
      bc(8'd201);
      rc(`AFI_OFS_IRQ_CAUSE, 8'h02);
      rc(`AFI_OFS_BUF_FILL, 8'h00);
      host.wr(`AFI_OFS_IRQ_PIN_SEL, 8'h80);
      host.wr(`AFI_OFS_IRQ_ENABLES, 8'h80);
      push(8'd202, 8'h00);
      wpin(1'b0, 1'b1);
      bc(8'd202);
      wpin(1'b0, 1'b0);
      host.wr(`AFI_OFS_OUT_FORMAT, 8'h20);
      wpin(1'b1, 1'b1);
      push(8'd203, 8'h00);
      wpin(1'b1, 1'b0);
      bc(8'd203);
      host.wr(`AFI_OFS_OUT_FORMAT, 8'h00);
      host.wr(`AFI_OFS_IRQ_ENABLES, 8'h00);
    end
  endtask
  task s_stream;
    begin
      host.wr(`AFI_OFS_BUF_CONTROL, 8'h80);
      for (i = 0; i < 40; i = i + 1)
        push(i[7:0], 8'h00);
      bc(8'd0);
      bc(8'd8);
      rc(`AFI_OFS_BUF_FILL, 8'h1e);
      host.wr(`AFI_OFS_BUF_CONTROL, 8'h00);
      host.burst(s);
    end
  endtask
  task s_trig;
    begin
      host.wr(`AFI_OFS_MOTION_THRESH, 8'h10);
      host.wr(`AFI_OFS_IRQ_PIN_SEL, 8'h00);
      host.wr(`AFI_OFS_IRQ_ENABLES, 8'h10);
      host.wr(`AFI_OFS_BUF_CONTROL, 8'hc3);
      for (i = 0; i < 11; i = i + 1)
        push(i[7:0], 8'h00);
      push(8'd11, 8'h20);
      wpin(1'b1, 1'b0);
      host.gap;
      rc(`AFI_OFS_BUF_FILL, 8'h83);
      bc(8'd0);
      bc(8'd9);
      rc(`AFI_OFS_IRQ_CAUSE, 8'h90);
      rc(`AFI_OFS_IRQ_CAUSE, 8'h80);
      wpin(1'b0, 1'b0);
      // Drain what the capture kept before bypass throws it away
      bc(8'd10);
      bc(8'd11);
      rc(`AFI_OFS_BUF_FILL, 8'h80);
      host.wr(`AFI_OFS_BUF_CONTROL, 8'h00);
      rc(`AFI_OFS_BUF_FILL, 8'h00);
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    // Watermark latches at the first edge after release, so read one edge later
    @(posedge sys_clk_i);
    rc(`AFI_OFS_IRQ_CAUSE, 8'h02);
    rc(6'h10, 8'h00);
    host.wr(`AFI_OFS_STILL_THRESH, 8'ha5);
    rc(`AFI_OFS_STILL_THRESH, 8'ha5);
    host.wr(`AFI_OFS_STILL_THRESH, 8'h00);
    s_fifo;
    s_bypass_irq;
    s_stream;
    s_trig;
    close_out;
  end
endmodule // tb_top
